// *** logic/rcb_pkg.sv ***
// Summary of operation
// - Overload enable set runs the chroma scaling mechanism; cleared leaves it idle.
// - Overload logic measures chroma each line and derives the Cr/Cb scale factor.
// - Blend mode applies only outside analog YCrCb mode; there fast blank is off.
// - Mode 00x mixes sources by fast blank in active line, soft 0 to 1.
// - Mode 01x mixes by fast blank, soft weight ramping from 0 to slope value.
// - Mode 100 ignores fast blank: alpha times RGB plus rest times composite.
// - Mode 101 ignores fast blank: alpha times composite plus rest times RGB.
// - Mode 110 outputs composite Y, Cb, Cr unchanged.
// - Mode 111 outputs RGB-derived Y unchanged, and RGB Cb, Cr after the overload scale factor.
// - Split select takes Y from composite, Cr/Cb from RGB, over blend mode.
// - Phase jump disable clear passes PLL phase jumps; set suppresses them.
// - In forced composite or forced RGB modes the slope register has no effect.
// - Alpha modes use the full 8-bit slope value as alpha, FF full scale.
// - Slope code sets transition length: 00 one cycle, 11 four, reset 01.
// - Override bit 2 set drives horizontal sync pad with bit 3.
// - Override bit 4 set drives vertical sync pad with bit 5.
// - Override bit 6 set drives field pad with bit 7.
// - Override bit 0 set drives lock pad with bit 1, else real lock.
package rcb_pkg;
	localparam logic [7:0] ADDR_BLEND_CTRL = 8'h05;
	localparam logic [7:0] ADDR_BLEND_SLOPE = 8'h06;
	localparam logic [7:0] ADDR_PAD_OVR = 8'h07;
	localparam logic [7:0] RST_BLEND_CTRL = 8'h20;
	localparam logic [7:0] RST_BLEND_SLOPE = 8'h01;
	localparam logic [7:0] RST_PAD_OVR = 8'h00;
	localparam int BIT_PHASE_DIS = 0;
	localparam int BIT_SPLIT = 1;
	localparam int MODE_LSB = 2;
	localparam int MODE_MSB = 4;
	localparam int BIT_CHROMA_OVL = 5;
	localparam int PAD_LOCK_EN = 0;
	localparam int PAD_LOCK_VAL = 1;
	localparam int PAD_HS_EN = 2;
	localparam int PAD_HS_VAL = 3;
	localparam int PAD_VS_EN = 4;
	localparam int PAD_VS_VAL = 5;
	localparam int PAD_FLD_EN = 6;
	localparam int PAD_FLD_VAL = 7;
	localparam logic [2:0] MODE_ALPHA_RGB = 3'h4;
	localparam logic [2:0] MODE_ALPHA_COMPOSITE_VIDEO_SOURCE = 3'h5;
	localparam logic [2:0] MODE_FORCE_COMPOSITE_VIDEO_SOURCE = 3'h6;
	localparam logic [2:0] MODE_FORCE_RGB = 3'h7;
	localparam logic [8:0] FULL_WEIGHT = 9'h100;
	localparam logic [7:0] CHROMA_LIMIT = 8'h70;
	localparam int SYNC_STAGES = 2;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	typedef enum logic [8:0] {
		I2C_IDLE = 9'h001,
		I2C_ADDR = 9'h002,
		I2C_ACKA = 9'h004,
		I2C_PTR = 9'h008,
		I2C_ACKP = 9'h010,
		I2C_WDATA = 9'h020,
		I2C_ACKW = 9'h040,
		I2C_RDATA = 9'h080,
		I2C_ACKR = 9'h100
	} rcb_i2c_state_e;
endpackage

// *** logic/rcb_sync.sv ***
module rcb_sync #(
	parameter int WIDTH = 1,
	parameter int STAGES = rcb_pkg::SYNC_STAGES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage_q [STAGES];

	// Only the next stage reads each flop; the last stage is the output
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < STAGES; i++) begin
				stage_q[i] <= '0;
			end
		end else if (ce) begin
			stage_q[0] <= asyncIn;
			for (int i = 1; i < STAGES; i++) begin
				stage_q[i] <= stage_q[i-1];
			end
		end
	end

	assign syncOut = stage_q[STAGES-1];
endmodule

// *** logic/rcb_mix.sv ***
module rcb_mix (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic [7:0] rgbVal,
	input wire logic [7:0] cvbsVal,
	input wire logic [8:0] weight,
	output logic [7:0] mixOut
);
	logic [16:0] sum;
	logic [8:0] restWeight;

	// Weight 256 passes the RGB value exactly, weight 0 the composite value
	always_comb begin
		restWeight = rcb_pkg::FULL_WEIGHT - weight;
		sum = ({9'h000, rgbVal} * {8'h00, weight}) + ({9'h000, cvbsVal} * {8'h00, restWeight});
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mixOut <= 8'h00;
		end else if (ce) begin
			mixOut <= sum[15:8];
		end
	end
endmodule

// *** logic/rcb_blend_top.sv ***
module rcb_blend_top #(
	// Bus address of the device; value is arbitrary
	parameter logic [6:0] DEV_ADDR = 7'h42
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic fastBlankIn,
	input wire logic activeVideo,
	input wire logic analogYcrcbMode,
	input wire logic [7:0] yCvbs,
	input wire logic [7:0] crCvbs,
	input wire logic [7:0] cbCvbs,
	input wire logic [7:0] yRgb,
	input wire logic [7:0] crRgb,
	input wire logic [7:0] cbRgb,
	output logic [7:0] yOut,
	output logic [7:0] crOut,
	output logic [7:0] cbOut,
	input wire logic phaseJumpReq,
	output logic pllPhaseJump,
	input wire logic hsyncIn,
	input wire logic vsyncIn,
	input wire logic fieldIn,
	input wire logic pllLockIn,
	output logic hsyncPad,
	output logic vsyncPad,
	output logic fieldPad,
	output logic lockPad
);
	rcb_pkg::rcb_i2c_state_e state_q;
	logic sclS, sdaS, fbS;
	logic sclSyncN, sdaSyncN;
	logic sclPrev_q, sdaPrev_q;
	logic sclRise, sclFall, startSeen, stopSeen;
	logic [3:0] bitCnt_q;
	logic [7:0] shift_q, txShift_q, ptr_q;
	logic isRead_q, sdaOe_q;
	logic wrStb_q;
	logic [7:0] wrAddr_q, wrData_q;
	logic [7:0] blendCtrl_q, blendSlope_q, padOvr_q;
	logic [7:0] readValue;
	logic [2:0] rampPos_q, rampLen;
	logic fbOn;
	logic [8:0] alpha9, rampTarget, rampW, wY, wC;
	logic [17:0] rampProd;
	logic [2:0] mode;
	logic activePrev_q;
	logic [7:0] peak_q;
	logic [8:0] scale_q, scaleFromPeak;
	logic [15:0] scaleQuot;
	logic [7:0] crAdj, cbAdj;
	logic [7:0] rgbArr [3];
	logic [7:0] cvbsArr [3];
	logic [8:0] wArr [3];
	logic [7:0] outArr [3];

	function automatic logic [7:0] chromaMag(input logic [7:0] c);
		return c[7] ? (c - 8'h80) : (8'h80 - c);
	endfunction

	function automatic logic [7:0] scaleChroma(input logic [7:0] c, input logic [8:0] s);
		logic signed [9:0] centred;
		logic signed [19:0] prod;
		logic signed [19:0] shifted;
		centred = $signed({2'b00, c}) - 10'sd128;
		prod = centred * $signed({1'b0, s});
		shifted = prod >>> 8;
		return {~shifted[7], shifted[6:0]};
	endfunction

	function automatic logic [8:0] rampFrac(input logic [2:0] pos, input logic [2:0] n);
		logic [8:0] f;
		f = 9'h000;
		if (pos >= n) begin
			f = rcb_pkg::FULL_WEIGHT;
		end else if (pos != 3'h0) begin
			case (n)
				3'h2: f = 9'h080;
				3'h3: f = (pos == 3'h1) ? 9'h055 : 9'h0ab;
				3'h4: f = {1'b0, pos[1:0], 6'h00};
				default: f = rcb_pkg::FULL_WEIGHT;
			endcase
		end
		return f;
	endfunction

	// Pins from outside the clock domain: bus lines and fast blank
	rcb_sync #(
		.WIDTH(3),
		.STAGES(rcb_pkg::SYNC_STAGES)
	) pinSync (
		.clk(clk),
		.rst_b(rst_b),
		.ce(ce),
		.asyncIn({~sclIn, ~sdaIn, fastBlankIn}),
		.syncOut({sclSyncN, sdaSyncN, fbS})
	);

	// Bus lines cross inverted so a cleared synchroniser reads as idle high
	assign sclS = ~sclSyncN;
	assign sdaS = ~sdaSyncN;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end else if (ce) begin
			sclPrev_q <= sclS;
			sdaPrev_q <= sdaS;
		end
	end

	assign sclRise = sclS && !sclPrev_q;
	assign sclFall = !sclS && sclPrev_q;
	assign startSeen = sclS && sclPrev_q && sdaPrev_q && !sdaS;
	assign stopSeen = sclS && sclPrev_q && !sdaPrev_q && sdaS;
	assign sdaOut = 1'b0;
	assign sdaOe = sdaOe_q;

	always_comb begin
		case (ptr_q)
			rcb_pkg::ADDR_BLEND_CTRL: readValue = blendCtrl_q;
			rcb_pkg::ADDR_BLEND_SLOPE: readValue = blendSlope_q;
			rcb_pkg::ADDR_PAD_OVR: readValue = padOvr_q;
			default: readValue = 8'h00;
		endcase
	end

	// Serial slave: pointer byte, then data bytes with auto increment
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= rcb_pkg::I2C_IDLE;
			bitCnt_q <= 4'h0;
			shift_q <= 8'h00;
			txShift_q <= 8'h00;
			ptr_q <= 8'h00;
			isRead_q <= 1'b0;
			sdaOe_q <= 1'b0;
			wrStb_q <= 1'b0;
			wrAddr_q <= 8'h00;
			wrData_q <= 8'h00;
		end else if (ce) begin
			wrStb_q <= 1'b0;
			if (startSeen) begin
				state_q <= rcb_pkg::I2C_ADDR;
				bitCnt_q <= 4'h0;
				sdaOe_q <= 1'b0;
			end else if (stopSeen) begin
				state_q <= rcb_pkg::I2C_IDLE;
				sdaOe_q <= 1'b0;
			end else if (sclRise) begin
				shift_q <= {shift_q[6:0], sdaS};
				if (state_q != rcb_pkg::I2C_IDLE && bitCnt_q < rcb_pkg::BITS_PER_BYTE) begin
					bitCnt_q <= bitCnt_q + 4'h1;
				end
			end else if (sclFall) begin
				case (state_q)
					rcb_pkg::I2C_ADDR: begin
						if (bitCnt_q == rcb_pkg::BITS_PER_BYTE) begin
							if (shift_q[7:1] == DEV_ADDR) begin
								isRead_q <= shift_q[0];
								sdaOe_q <= 1'b1;
								state_q <= rcb_pkg::I2C_ACKA;
							end else begin
								state_q <= rcb_pkg::I2C_IDLE;
							end
						end
					end
					rcb_pkg::I2C_ACKA: begin
						bitCnt_q <= 4'h0;
						if (isRead_q) begin
							sdaOe_q <= ~readValue[7];
							txShift_q <= {readValue[6:0], 1'b0};
							ptr_q <= ptr_q + 8'h01;
							state_q <= rcb_pkg::I2C_RDATA;
						end else begin
							sdaOe_q <= 1'b0;
							state_q <= rcb_pkg::I2C_PTR;
						end
					end
					rcb_pkg::I2C_PTR: begin
						if (bitCnt_q == rcb_pkg::BITS_PER_BYTE) begin
							ptr_q <= shift_q;
							sdaOe_q <= 1'b1;
							state_q <= rcb_pkg::I2C_ACKP;
						end
					end
					rcb_pkg::I2C_ACKP, rcb_pkg::I2C_ACKW: begin
						sdaOe_q <= 1'b0;
						bitCnt_q <= 4'h0;
						state_q <= rcb_pkg::I2C_WDATA;
					end
					rcb_pkg::I2C_WDATA: begin
						if (bitCnt_q == rcb_pkg::BITS_PER_BYTE) begin
							wrStb_q <= 1'b1;
							wrAddr_q <= ptr_q;
							wrData_q <= shift_q;
							ptr_q <= ptr_q + 8'h01;
							sdaOe_q <= 1'b1;
							state_q <= rcb_pkg::I2C_ACKW;
						end
					end
					rcb_pkg::I2C_RDATA: begin
						if (bitCnt_q == rcb_pkg::BITS_PER_BYTE) begin
							sdaOe_q <= 1'b0;
							bitCnt_q <= 4'h0;
							state_q <= rcb_pkg::I2C_ACKR;
						end else begin
							sdaOe_q <= ~txShift_q[7];
							txShift_q <= {txShift_q[6:0], 1'b0};
						end
					end
					rcb_pkg::I2C_ACKR: begin
						// Master not acknowledging ends the read
						if (shift_q[0]) begin
							state_q <= rcb_pkg::I2C_IDLE;
						end else begin
							sdaOe_q <= ~readValue[7];
							txShift_q <= {readValue[6:0], 1'b0};
							ptr_q <= ptr_q + 8'h01;
							state_q <= rcb_pkg::I2C_RDATA;
						end
					end
					default: state_q <= rcb_pkg::I2C_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			blendCtrl_q <= rcb_pkg::RST_BLEND_CTRL;
			blendSlope_q <= rcb_pkg::RST_BLEND_SLOPE;
			padOvr_q <= rcb_pkg::RST_PAD_OVR;
		end else if (ce && wrStb_q) begin
			case (wrAddr_q)
				rcb_pkg::ADDR_BLEND_CTRL: blendCtrl_q <= wrData_q;
				rcb_pkg::ADDR_BLEND_SLOPE: blendSlope_q <= wrData_q;
				rcb_pkg::ADDR_PAD_OVR: padOvr_q <= wrData_q;
				default: blendCtrl_q <= blendCtrl_q;
			endcase
		end
	end

	// Soft mix ramp position, one step per mixing clock
	assign fbOn = fbS && activeVideo;
	assign rampLen = {1'b0, blendSlope_q[1:0]} + 3'h1;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rampPos_q <= 3'h0;
		end else if (ce) begin
			if (fbOn) begin
				rampPos_q <= (rampPos_q >= rampLen) ? rampLen : rampPos_q + 3'h1;
			end else if (rampPos_q != 3'h0) begin
				rampPos_q <= rampPos_q - 3'h1;
			end
		end
	end

	// Chroma overload: peak excursion per line sets next line's scale
	always_comb begin
		scaleQuot = {rcb_pkg::CHROMA_LIMIT, 8'h00} / {8'h00, peak_q};
		scaleFromPeak = (peak_q > rcb_pkg::CHROMA_LIMIT) ? scaleQuot[8:0] : rcb_pkg::FULL_WEIGHT;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			activePrev_q <= 1'b0;
			peak_q <= 8'h00;
			scale_q <= rcb_pkg::FULL_WEIGHT;
		end else if (ce) begin
			activePrev_q <= activeVideo;
			if (!blendCtrl_q[rcb_pkg::BIT_CHROMA_OVL]) begin
				peak_q <= 8'h00;
				scale_q <= rcb_pkg::FULL_WEIGHT;
			end else if (activeVideo) begin
				if (chromaMag(crRgb) > peak_q && chromaMag(crRgb) >= chromaMag(cbRgb)) begin
					peak_q <= chromaMag(crRgb);
				end else if (chromaMag(cbRgb) > peak_q) begin
					peak_q <= chromaMag(cbRgb);
				end
			end else if (activePrev_q) begin
				scale_q <= scaleFromPeak;
				peak_q <= 8'h00;
			end
		end
	end

	assign crAdj = scaleChroma(crRgb, scale_q);
	assign cbAdj = scaleChroma(cbRgb, scale_q);

	// Weights given to the RGB source, 256 meaning full RGB
	always_comb begin
		mode = blendCtrl_q[rcb_pkg::MODE_MSB:rcb_pkg::MODE_LSB];
		alpha9 = {1'b0, blendSlope_q} + {8'h00, blendSlope_q[7]};
		rampTarget = mode[1] ? alpha9 : rcb_pkg::FULL_WEIGHT;
		rampProd = {9'h000, rampTarget} * {9'h000, rampFrac(rampPos_q, rampLen)};
		rampW = rampProd[16:8];
		case (mode)
			rcb_pkg::MODE_ALPHA_RGB: wY = alpha9;
			rcb_pkg::MODE_ALPHA_COMPOSITE_VIDEO_SOURCE: wY = rcb_pkg::FULL_WEIGHT - alpha9;
			rcb_pkg::MODE_FORCE_COMPOSITE_VIDEO_SOURCE: wY = 9'h000;
			rcb_pkg::MODE_FORCE_RGB: wY = rcb_pkg::FULL_WEIGHT;
			default: wY = rampW;
		endcase
		wC = wY;
		if (analogYcrcbMode) begin
			wY = 9'h000;
			wC = 9'h000;
		end
		if (blendCtrl_q[rcb_pkg::BIT_SPLIT]) begin
			wY = 9'h000;
			wC = rcb_pkg::FULL_WEIGHT;
		end
	end

	assign rgbArr[0] = yRgb;
	assign rgbArr[1] = crAdj;
	assign rgbArr[2] = cbAdj;
	assign cvbsArr[0] = yCvbs;
	assign cvbsArr[1] = crCvbs;
	assign cvbsArr[2] = cbCvbs;
	assign wArr[0] = wY;
	assign wArr[1] = wC;
	assign wArr[2] = wC;

	for (genvar i = 0; i < 3; i++) begin : gMix
		rcb_mix mixer (
			.clk(clk),
			.rst_b(rst_b),
			.ce(ce),
			.rgbVal(rgbArr[i]),
			.cvbsVal(cvbsArr[i]),
			.weight(wArr[i]),
			.mixOut(outArr[i])
		);
	end

	assign yOut = outArr[0];
	assign crOut = outArr[1];
	assign cbOut = outArr[2];

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pllPhaseJump <= 1'b0;
		end else if (ce) begin
			pllPhaseJump <= phaseJumpReq && !blendCtrl_q[rcb_pkg::BIT_PHASE_DIS];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hsyncPad <= 1'b0;
			vsyncPad <= 1'b0;
			fieldPad <= 1'b0;
			lockPad <= 1'b0;
		end else if (ce) begin
			hsyncPad <= padOvr_q[rcb_pkg::PAD_HS_EN] ? padOvr_q[rcb_pkg::PAD_HS_VAL] : hsyncIn;
			vsyncPad <= padOvr_q[rcb_pkg::PAD_VS_EN] ? padOvr_q[rcb_pkg::PAD_VS_VAL] : vsyncIn;
			fieldPad <= padOvr_q[rcb_pkg::PAD_FLD_EN] ? padOvr_q[rcb_pkg::PAD_FLD_VAL] : fieldIn;
			lockPad <= padOvr_q[rcb_pkg::PAD_LOCK_EN] ? padOvr_q[rcb_pkg::PAD_LOCK_VAL] : pllLockIn;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence fbHeldLong;
		(ce && fbOn && !mode[2] && blendSlope_q[1:0] == 2'h3 && rampPos_q <= 3'h4)[*4];
	endsequence

	sequence fbHeldShort;
		ce && fbOn && !mode[2] && blendSlope_q[1:0] == 2'h0 && rampPos_q <= 3'h1;
	endsequence

	ramp_four_a: assert property (fbHeldLong |=> rampPos_q == 3'h4)
		else $error("ramp did not reach four steps");
	ramp_one_a: assert property (fbHeldShort |=> rampPos_q == 3'h1 && rampW == rampTarget)
		else $error("one cycle ramp not at full weight");
	forced_rgb_a: assert property (ce && mode == rcb_pkg::MODE_FORCE_RGB && !analogYcrcbMode &&
		!blendCtrl_q[rcb_pkg::BIT_SPLIT] |=> yOut == $past(yRgb))
		else $error("forced rgb output wrong");
	forced_composite_video_source_a: assert property (ce && mode == rcb_pkg::MODE_FORCE_COMPOSITE_VIDEO_SOURCE &&
		!blendCtrl_q[rcb_pkg::BIT_SPLIT] |=> yOut == $past(yCvbs) && crOut == $past(crCvbs))
		else $error("forced composite output wrong");
	split_select_a: assert property (ce && blendCtrl_q[rcb_pkg::BIT_SPLIT]
		|=> yOut == $past(yCvbs) && crOut == $past(crAdj))
		else $error("split component selection wrong");
	analog_mode_a: assert property (ce && analogYcrcbMode && !blendCtrl_q[rcb_pkg::BIT_SPLIT]
		|=> cbOut == $past(cbCvbs))
		else $error("analog mode did not pass composite");
	overload_off_a: assert property (ce && !blendCtrl_q[rcb_pkg::BIT_CHROMA_OVL]
		|=> scale_q == rcb_pkg::FULL_WEIGHT && peak_q == 8'h00)
		else $error("overload active while disabled");
	phase_jump_a: assert property (ce |=> pllPhaseJump ==
		($past(phaseJumpReq) && !$past(blendCtrl_q[rcb_pkg::BIT_PHASE_DIS])))
		else $error("phase jump gating wrong");
	hsync_pad_a: assert property (ce |=> hsyncPad == ($past(padOvr_q[rcb_pkg::PAD_HS_EN]) ?
		$past(padOvr_q[rcb_pkg::PAD_HS_VAL]) : $past(hsyncIn)))
		else $error("hsync pad wrong");
	vsync_pad_a: assert property (ce && padOvr_q[rcb_pkg::PAD_VS_EN]
		|=> vsyncPad == $past(padOvr_q[rcb_pkg::PAD_VS_VAL]))
		else $error("vsync pad override wrong");
	field_pad_a: assert property (ce && !padOvr_q[rcb_pkg::PAD_FLD_EN]
		|=> fieldPad == $past(fieldIn))
		else $error("field pad normal function wrong");
	lock_pad_a: assert property (ce && padOvr_q[rcb_pkg::PAD_LOCK_EN]
		|=> lockPad == $past(padOvr_q[rcb_pkg::PAD_LOCK_VAL]))
		else $error("lock pad override wrong");
endmodule

// *** verification/rcb_video_sink.sv ***
module rcb_video_sink (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic pllPhaseJump,
	input wire logic [7:0] yOut,
	output logic [7:0] jumpCount,
	output logic [7:0] lastY
);
	timeunit 1ns;
	timeprecision 1ps;
	// Counts the phase jump pulses that reach the output PLL
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			jumpCount <= 8'h00;
		end else if (pllPhaseJump) begin
			jumpCount <= jumpCount + 8'h01;
		end
	end
	always_ff @(posedge clk) begin
		lastY <= yOut;
	end
endmodule

// *** verification/tb_top.sv ***
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [6:0] DEV = 7'h42;
	localparam logic [8:0] WT [4] = '{9'h040, 9'h0c0, 9'h000, 9'h100};
	localparam logic [7:0] PADP [4] = '{8'h00, 8'hff, 8'h55, 8'haa};
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic sclIn = 1'b1, sdaM = 1'b1, fastBlankIn = 1'b0, activeVideo = 1'b0;
	logic analogYcrcbMode = 1'b0, phaseJumpReq = 1'b0;
	logic hsyncIn = 1'b0, vsyncIn = 1'b1, fieldIn = 1'b0, pllLockIn = 1'b1;
	logic [7:0] yCvbs = 8'h40, crCvbs = 8'h60, cbCvbs = 8'h50;
	logic [7:0] yRgb = 8'hc0, crRgb = 8'ha0, cbRgb = 8'h90;
	logic sdaIn, sdaOut, sdaOe, pllPhaseJump, hsyncPad, vsyncPad, fieldPad, lockPad;
	logic [7:0] yOut, crOut, cbOut, jumpCount, lastY;
	int errors = 0;
	int checks = 0;
	// Open-drain wire with pull-up
	assign sdaIn = sdaM & (sdaOe ? sdaOut : 1'b1);
	always #2 clk = ~clk;
	rcb_blend_top #(.DEV_ADDR(DEV)) u_dut (.clk(clk), .rst_b(rst_b), .ce(1'b1), .sclIn(sclIn),
		.sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .fastBlankIn(fastBlankIn),
		.activeVideo(activeVideo), .analogYcrcbMode(analogYcrcbMode), .yCvbs(yCvbs),
		.crCvbs(crCvbs), .cbCvbs(cbCvbs), .yRgb(yRgb), .crRgb(crRgb), .cbRgb(cbRgb),
		.yOut(yOut), .crOut(crOut), .cbOut(cbOut), .phaseJumpReq(phaseJumpReq),
		.pllPhaseJump(pllPhaseJump), .hsyncIn(hsyncIn), .vsyncIn(vsyncIn), .fieldIn(fieldIn),
		.pllLockIn(pllLockIn), .hsyncPad(hsyncPad), .vsyncPad(vsyncPad), .fieldPad(fieldPad),
		.lockPad(lockPad));
	rcb_video_sink u_sink (.clk(clk), .rst_b(rst_b), .pllPhaseJump(pllPhaseJump), .yOut(yOut),
		.jumpCount(jumpCount), .lastY(lastY));
	task automatic close_out;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [7:0] mixv(input logic [7:0] r, input logic [7:0] c,
		input logic [8:0] w);
		logic [17:0] t;
		t = r * w + c * (9'h100 - w);
		return t[15:8];
	endfunction
	task automatic chkPix(input logic [8:0] wy, input logic [8:0] wc);
		repeat (4) @(posedge clk);
		#1;
		chk(yOut, mixv(yRgb, yCvbs, wy));
		chk(lastY, mixv(yRgb, yCvbs, wy));
		chk(crOut, mixv(crRgb, crCvbs, wc));
		chk(cbOut, mixv(cbRgb, cbCvbs, wc));
	endtask
	// One bus phase lasts eight clocks, well above the minimum phase length
	task automatic bus(input logic c, input logic d);
		@(posedge clk);
		sclIn <= c;
		sdaM <= d;
		repeat (7) @(posedge clk);
		#1;
	endtask
	task automatic start;
		bus(1'b0, 1'b1);
		bus(1'b1, 1'b1);
		bus(1'b1, 1'b0);
		bus(1'b0, 1'b0);
	endtask
	task automatic stop;
		bus(1'b0, 1'b0);
		bus(1'b1, 1'b0);
		bus(1'b1, 1'b1);
	endtask
	task automatic sendByte(input logic [7:0] v, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bus(1'b0, v[i]);
			bus(1'b1, v[i]);
			bus(1'b0, v[i]);
		end
		bus(1'b0, 1'b1);
		bus(1'b1, 1'b1);
		ack = sdaOe;
		bus(1'b0, 1'b1);
	endtask
	task automatic regWr(input logic [7:0] a, input logic [7:0] d);
		logic k;
		start();
		sendByte({DEV, 1'b0}, k);
		chk({7'h00, k}, 8'h01);
		sendByte(a, k);
		sendByte(d, k);
		stop();
	endtask
	task automatic regRd(input logic [7:0] a, output logic [7:0] v);
		logic k;
		start();
		sendByte({DEV, 1'b0}, k);
		sendByte(a, k);
		start();
		sendByte({DEV, 1'b1}, k);
		for (int i = 7; i >= 0; i--) begin
			bus(1'b0, 1'b1);
			bus(1'b1, 1'b1);
			v[i] = sdaIn;
			bus(1'b0, 1'b1);
		end
		bus(1'b0, 1'b1);
		bus(1'b1, 1'b1);
		bus(1'b0, 1'b1);
		stop();
	endtask
	task automatic line;
		@(posedge clk);
		activeVideo <= 1'b1;
		repeat (10) @(posedge clk);
		activeVideo <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
	endtask
	initial begin
		repeat (90000) @(posedge clk);
		errors++;
		$display("[FAIL] %0t run limit reached", $time);
		close_out();
	end
	initial begin
		logic [7:0] v;
		logic k;
		int n;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		regRd(8'h05, v);
		chk(v, 8'h20);
		regRd(8'h06, v);
		chk(v, 8'h01);
		regRd(8'h07, v);
		chk(v, 8'h00);
		regWr(8'h08, 8'h5a);
		regRd(8'h08, v);
		chk(v, 8'h00);
		start();
		sendByte({DEV ^ 7'h01, 1'b0}, k);
		chk({7'h00, k}, 8'h00);
		stop();
		for (int m = 4; m < 8; m++) begin
			regWr(8'h05, {3'b001, 3'(m), 2'b00});
			if (m == 4) begin
				regWr(8'h06, 8'h40);
			end
			chkPix(WT[m-4], WT[m-4]);
		end
		regWr(8'h06, 8'h80);
		chkPix(9'h100, 9'h100);
		regWr(8'h05, 8'h38);
		chkPix(9'h000, 9'h000);
		regWr(8'h05, 8'h30);
		regWr(8'h06, 8'hff);
		chkPix(9'h100, 9'h100);
		regWr(8'h05, 8'h3a);
		chkPix(9'h000, 9'h100);
		regWr(8'h05, 8'h3c);
		@(posedge clk);
		analogYcrcbMode <= 1'b1;
		chkPix(9'h000, 9'h000);
		regWr(8'h05, 8'h3e);
		chkPix(9'h000, 9'h100);
		@(posedge clk);
		analogYcrcbMode <= 1'b0;
		regWr(8'h06, 8'h00);
		regWr(8'h05, 8'h20);
		for (int c = 0; c < 4; c++) begin
			regWr(8'h06, 8'(c));
			@(posedge clk);
			fastBlankIn <= 1'b1;
			activeVideo <= 1'b1;
			n = 0;
			repeat (30) begin
				@(posedge clk);
				#1;
				if (yOut !== 8'h40 && yOut !== 8'hc0) n++;
			end
			chk(8'(n), 8'(c));
			chk(yOut, 8'hc0);
			@(posedge clk);
			fastBlankIn <= 1'b0;
			repeat (30) @(posedge clk);
		end
		@(posedge clk);
		fastBlankIn <= 1'b1;
		activeVideo <= 1'b0;
		chkPix(9'h000, 9'h000);
		regWr(8'h05, 8'h28);
		regWr(8'h06, 8'h80);
		@(posedge clk);
		activeVideo <= 1'b1;
		chkPix(9'h081, 9'h081);
		@(posedge clk);
		fastBlankIn <= 1'b0;
		activeVideo <= 1'b0;
		regWr(8'h05, 8'h3c);
		@(posedge clk);
		crRgb <= 8'hff;
		line();
		chk(crOut, 8'hef);
		regWr(8'h05, 8'h1c);
		line();
		chk(crOut, 8'hff);
		@(posedge clk);
		crRgb <= 8'ha0;
		for (int d = 0; d < 2; d++) begin
			regWr(8'h05, 8'h3c | 8'(d));
			@(posedge clk);
			phaseJumpReq <= 1'b1;
			@(posedge clk);
			phaseJumpReq <= 1'b0;
			#1;
			chk({7'h00, pllPhaseJump}, 8'(1 - d));
		end
		repeat (2) @(posedge clk);
		#1;
		chk(jumpCount, 8'h01);
		for (int i = 0; i < 4; i++) begin
			v = PADP[i];
			regWr(8'h07, v);
			repeat (4) @(posedge clk);
			#1;
			chk({7'h00, hsyncPad}, {7'h00, v[2] ? v[3] : hsyncIn});
			chk({7'h00, vsyncPad}, {7'h00, v[4] ? v[5] : vsyncIn});
			chk({7'h00, fieldPad}, {7'h00, v[6] ? v[7] : fieldIn});
			chk({7'h00, lockPad}, {7'h00, v[0] ? v[1] : pllLockIn});
		end
		regRd(8'h07, v);
		chk(v, 8'haa);
		close_out();
	end
endmodule
